/* hdl/adc_port_cfg.svh */
// Offsets, field positions, reset values and counts of the converter serial port
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH

// Register addresses carried in the low six bits of the command byte
`define ADDR_STATUS      6'h00
`define ADDR_MODE        6'h01
`define ADDR_IFMODE      6'h02
`define ADDR_DATA        6'h04

// Data lengths in bits
`define LEN_STATUS       6'h08
`define LEN_MODE         6'h10
`define LEN_IFMODE       6'h10
`define LEN_DATA         6'h18
`define LEN_UNMAPPED     6'h08

// Command byte fields
`define CMD_WEN_BIT      7
`define CMD_RD_BIT       6

// Interface mode register fields
`define IFM_CONTINUOUS_READ_ENABLE_BIT 7
`define IFM_CHK_MSB      3
`define IFM_CHK_LSB      2

// Status register fields
`define STAT_RDY_BIT     7
`define STAT_CRCERR_BIT  6

// Power-on values
`define MODE_RST         16'h0000
`define IFMODE_RST       16'h0000
`define DATA_RST         24'h000000

// Protocol constants
`define DUMMY_READ_CMD   8'h44
`define RESET_ONES       7'h40
`define CRC_POLY         8'h07

`endif

/* hdl/adc_port_pkg.sv */
// Types shared by the converter serial port
package adc_port_pkg;

  // Transfer phases, Gray coded along command, data, checksum
  typedef enum logic [2:0] {
    ST_CMD   = 3'h0,
    ST_WDATA = 3'h1,
    ST_WCRC  = 3'h3,
    ST_RDATA = 3'h2,
    ST_RCRC  = 3'h6
  } port_state_t;

  // Checksum select field encodings
  typedef enum logic [1:0] {
    CHK_OFF = 2'h0,
    CHK_XOR = 2'h1,
    CHK_CRC = 2'h2,
    CHK_ALT = 2'h3
  } chk_mode_t;

endpackage

/* hdl/port_checksum.sv */
// Polynomial and byte-XOR checksum over a left-aligned message of 2 to 5 bytes
`include "adc_port_cfg.svh"

module port_checksum (
  // Message
  input  wire logic [39:0] msg,
  input  wire logic [2:0]  nbytes,
  input  wire logic        use_xor,
  // Result
  output logic      [7:0]  sum
);

  logic [7:0] crc;
  logic [7:0] xsum;
  logic       fb;

  // Bitwise division, same remainder as appending eight zeros
  always_comb begin
    crc  = 8'h00;
    xsum = 8'h00;
    fb   = 1'b0;
    for (int i = 0; i < 40; i++) begin
      if (i < 8 * int'(nbytes)) begin
        fb  = crc[7] ^ msg[39 - i];
        crc = {crc[6:0], 1'b0} ^ (fb ? `CRC_POLY : 8'h00);
      end
    end
    for (int b = 0; b < 5; b++) begin
      if (b < int'(nbytes)) begin
        xsum = xsum ^ msg[39 - 8 * b -: 8];
      end
    end
    sum = use_xor ? xsum : crc;
  end

endmodule

/* hdl/adc_serial_port.sv */
// Serial register port of a sigma-delta converter with checksum protection
`include "adc_port_cfg.svh"

module adc_serial_port
  import adc_port_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Serial pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  // Converter result strobe
  input  wire logic        conv_valid,
  input  wire logic [23:0] conv_data,
  // Status and configuration
  output logic             ready_n,
  output logic             crc_error,
  output logic             continuous_read_enable,
  output logic [1:0]       chk_mode,
  output logic [15:0]      mode_word,
  output logic             iface_reset
);

  // Length of each register in bits
  function automatic logic [5:0] reg_len(input logic [5:0] a);
    case (a)
      `ADDR_STATUS: reg_len = `LEN_STATUS;
      `ADDR_MODE:   reg_len = `LEN_MODE;
      `ADDR_IFMODE: reg_len = `LEN_IFMODE;
      `ADDR_DATA:   reg_len = `LEN_DATA;
      default:      reg_len = `LEN_UNMAPPED;
    endcase
  endfunction

  // Move a right-aligned word of len bits to the top of 32
  function automatic logic [31:0] align(input logic [31:0] v, input logic [5:0] len);
    align = v << (6'h20 - len);
  endfunction

  // Pin synchronisers
  logic cs_s1, cs_s2, sclk_s1, sclk_s2, sclk_s3, din_s1, din_s2;

  // Port state
  port_state_t state_reg, state_next;
  logic [5:0]  bit_cnt_reg, bit_cnt_next;
  logic [6:0]  ones_reg, ones_next;
  logic [7:0]  cmd_reg, cmd_next;
  logic [31:0] rx_reg, rx_next;
  logic [31:0] tx_reg, tx_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] wdat_reg, wdat_next;
  logic        live_reg, live_next;
  logic        dout_reg, dout_next;
  logic        rst_pulse_reg, rst_pulse_next;

  // Register file and conversion state
  logic [15:0] mode_reg, mode_next;
  logic [15:0] ifmode_reg, ifmode_next;
  logic [23:0] data_reg, data_next;
  logic [23:0] pend_data_reg, pend_data_next;
  logic        pend_reg, pend_next;
  logic        rdy_reg, rdy_next;
  logic        crcerr_reg, crcerr_next;

  logic        rise, fall, sel, din_bit;
  logic [5:0]  len;
  logic        chk_on;
  logic [39:0] chk_msg;
  logic [2:0]  chk_bytes;
  logic        chk_xor;
  logic [7:0]  chk_sum;
  logic [7:0]  status_val;
  logic [31:0] rd_val;

  // Two flops per pin, three on sclk; the edge detector reads only the second and third
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_s3 <= 1'b1;
      din_s1  <= 1'b0;
      din_s2  <= 1'b0;
    end else begin
      cs_s1   <= cs_n;
      cs_s2   <= cs_s1;
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      din_s1  <= din;
      din_s2  <= din_s1;
    end
  end

  // Edges of the host clock; din is delayed equally so it is sampled at the edge
  assign rise    = sclk_s2 & ~sclk_s3;
  assign fall    = ~sclk_s2 & sclk_s3;
  assign sel     = ~cs_s2;
  assign din_bit = din_s2;

  assign len        = reg_len(cmd_reg[5:0]);
  assign chk_on     = (ifmode_reg[`IFM_CHK_MSB:`IFM_CHK_LSB] != CHK_OFF);
  assign status_val = {rdy_reg, crcerr_reg, 6'h00};

  // Value returned by a read; address taken from the shifter, not the next-state logic
  always_comb begin
    case ({rx_reg[4:0], din_bit})
      `ADDR_STATUS: rd_val = {24'h000000, status_val};
      `ADDR_MODE:   rd_val = {16'h0000, mode_reg};
      `ADDR_IFMODE: rd_val = {16'h0000, ifmode_reg};
      `ADDR_DATA:   rd_val = {8'h00, data_reg};
      default:      rd_val = 32'h00000000;
    endcase
  end

  // Reads checksum the command and output data; writes always use the polynomial
  always_comb begin
    chk_bytes = 3'h1 + len[5:3]; // Command byte plus len / 8 data bytes
    if (state_reg == ST_RDATA || state_reg == ST_RCRC) begin
      chk_msg = {cmd_reg, align(rdata_reg, len)};
      chk_xor = (ifmode_reg[`IFM_CHK_MSB:`IFM_CHK_LSB] == CHK_XOR);
    end else begin
      chk_msg = {cmd_reg, align(wdat_reg, len)};
      chk_xor = 1'b0;
    end
  end

  port_checksum u_chk (
    .msg    (chk_msg),
    .nbytes (chk_bytes),
    .use_xor(chk_xor),
    .sum    (chk_sum)
  );

  // Next-state logic of the transfer engine and the register file
  always_comb begin
    state_next     = state_reg;
    bit_cnt_next   = bit_cnt_reg;
    ones_next      = ones_reg;
    cmd_next       = cmd_reg;
    rx_next        = rx_reg;
    tx_next        = tx_reg;
    rdata_next     = rdata_reg;
    wdat_next      = wdat_reg;
    live_next      = live_reg;
    rst_pulse_next = 1'b0;
    mode_next      = mode_reg;
    ifmode_next    = ifmode_reg;
    data_next      = data_reg;
    pend_data_next = pend_data_reg;
    pend_next      = pend_reg;
    rdy_next       = rdy_reg;
    crcerr_next    = crcerr_reg;

    if (!sel) begin
      // Deselect aborts any transfer; the next byte is a command
      state_next   = ST_CMD;
      bit_cnt_next = 6'h00;
      ones_next    = 7'h00;
      live_next    = 1'b0;
    end else if (rise && din_bit && ones_reg == `RESET_ONES - 7'h01) begin
      // 64th consecutive high bit: whole port back to power-on
      state_next     = ST_CMD;
      bit_cnt_next   = 6'h00;
      ones_next      = 7'h00;
      live_next      = 1'b0;
      rst_pulse_next = 1'b1;
      mode_next      = `MODE_RST;
      ifmode_next    = `IFMODE_RST;
      data_next      = `DATA_RST;
      pend_next      = 1'b0;
      rdy_next       = 1'b1;
      crcerr_next    = 1'b0;
    end else begin
      if (rise) begin
        ones_next = din_bit ? ones_reg + 7'h01 : 7'h00;
        rx_next   = {rx_reg[30:0], din_bit};
      end
      // Output bits change on falling edges, after the first one of a phase
      if (fall && (state_reg == ST_RDATA || state_reg == ST_RCRC)) begin
        live_next = 1'b1;
        if (live_reg && bit_cnt_reg != 6'h00) begin
          tx_next = {tx_reg[30:0], 1'b0};
        end
      end
      unique case (state_reg)
        ST_CMD: begin
          if (ifmode_reg[`IFM_CONTINUOUS_READ_ENABLE_BIT]) begin
            // Continuous read: each fresh result goes out once; commands ignored, except a dummy read command sent during the data, which ends the mode
            if (!rdy_reg) begin
              cmd_next     = `DUMMY_READ_CMD;
              rdata_next   = {8'h00, data_reg};
              tx_next      = align({8'h00, data_reg}, `LEN_DATA);
              bit_cnt_next = 6'h00;
              live_next    = 1'b0;
              state_next   = ST_RDATA;
            end
          end else if (rise) begin
            bit_cnt_next = bit_cnt_reg + 6'h01;
            if (bit_cnt_reg == 6'h07) begin
              bit_cnt_next = 6'h00;
              cmd_next     = {rx_reg[6:0], din_bit};
              live_next    = 1'b0;
              if (!cmd_next[`CMD_WEN_BIT]) begin
                if (cmd_next[`CMD_RD_BIT]) begin
                  rdata_next = rd_val;
                  tx_next    = align(rd_val, reg_len(cmd_next[5:0]));
                  state_next = ST_RDATA;
                end else begin
                  state_next = ST_WDATA;
                end
              end
            end
          end
        end
        ST_RDATA: begin
          if (rise) begin
            bit_cnt_next = bit_cnt_reg + 6'h01;
            if (bit_cnt_reg == len - 6'h01) begin
              bit_cnt_next = 6'h00;
              if (cmd_reg[5:0] == `ADDR_DATA) begin
                rdy_next = 1'b1;
              end
              if (cmd_reg[5:0] == `ADDR_STATUS) begin
                crcerr_next = 1'b0;
              end
              if (ifmode_reg[`IFM_CONTINUOUS_READ_ENABLE_BIT] && rx_reg[22:15] == `DUMMY_READ_CMD) begin
                ifmode_next[`IFM_CONTINUOUS_READ_ENABLE_BIT] = 1'b0;
              end
              if (chk_on) begin
                tx_next    = {chk_sum, 24'h000000};
                state_next = ST_RCRC;
              end else begin
                state_next = ST_CMD;
              end
            end
          end
        end
        ST_RCRC: begin
          if (rise) begin
            bit_cnt_next = bit_cnt_reg + 6'h01;
            if (bit_cnt_reg == 6'h07) begin
              bit_cnt_next = 6'h00;
              state_next   = ST_CMD;
            end
          end
        end
        ST_WDATA: begin
          if (rise) begin
            bit_cnt_next = bit_cnt_reg + 6'h01;
            if (bit_cnt_reg == len - 6'h01) begin
              bit_cnt_next = 6'h00;
              wdat_next    = {rx_reg[30:0], din_bit};
              state_next   = chk_on ? ST_WCRC : ST_CMD;
            end
          end
        end
        ST_WCRC: begin
          if (rise) begin
            bit_cnt_next = bit_cnt_reg + 6'h01;
            if (bit_cnt_reg == 6'h07) begin
              bit_cnt_next = 6'h00;
              state_next   = ST_CMD;
              if ({rx_reg[6:0], din_bit} != chk_sum) begin
                crcerr_next = 1'b1;
              end
            end
          end
        end
        default: begin
          state_next = ST_CMD;
        end
      endcase
      // Commit a write once its data, and a matching checksum if enabled, are in
      if (rise && ((state_reg == ST_WDATA && !chk_on && bit_cnt_reg == len - 6'h01) ||
                   (state_reg == ST_WCRC && bit_cnt_reg == 6'h07 &&
                    {rx_reg[6:0], din_bit} == chk_sum))) begin
        case (cmd_reg[5:0])
          `ADDR_MODE:   mode_next   = wdat_next[15:0];
          `ADDR_IFMODE: ifmode_next = wdat_next[15:0];
          default:      mode_next   = mode_next;
        endcase
      end
    end

    // New result: raise ready first, load on the following cycle
    if (pend_reg) begin
      data_next = pend_data_reg;
      rdy_next  = 1'b0;
      pend_next = 1'b0;
    end
    if (conv_valid) begin
      pend_data_next = conv_data;
      pend_next      = 1'b1;
      rdy_next       = 1'b1;
    end

    // Pin shows data while a read phase is live, ready otherwise
    dout_next = (live_next && (state_next == ST_RDATA || state_next == ST_RCRC)) ?
                tx_next[31] : rdy_next;
  end

  // Register the transfer engine and register file
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg     <= ST_CMD;
      bit_cnt_reg   <= 6'h00;
      ones_reg      <= 7'h00;
      cmd_reg       <= 8'h00;
      rx_reg        <= 32'h00000000;
      tx_reg        <= 32'h00000000;
      rdata_reg     <= 32'h00000000;
      wdat_reg      <= 32'h00000000;
      live_reg      <= 1'b0;
      dout_reg      <= 1'b1;
      rst_pulse_reg <= 1'b0;
      mode_reg      <= `MODE_RST;
      ifmode_reg    <= `IFMODE_RST;
      data_reg      <= `DATA_RST;
      pend_data_reg <= `DATA_RST;
      pend_reg      <= 1'b0;
      rdy_reg       <= 1'b1;
      crcerr_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      bit_cnt_reg   <= bit_cnt_next;
      ones_reg      <= ones_next;
      cmd_reg       <= cmd_next;
      rx_reg        <= rx_next;
      tx_reg        <= tx_next;
      rdata_reg     <= rdata_next;
      wdat_reg      <= wdat_next;
      live_reg      <= live_next;
      dout_reg      <= dout_next;
      rst_pulse_reg <= rst_pulse_next;
      mode_reg      <= mode_next;
      ifmode_reg    <= ifmode_next;
      data_reg      <= data_next;
      pend_data_reg <= pend_data_next;
      pend_reg      <= pend_next;
      rdy_reg       <= rdy_next;
      crcerr_reg    <= crcerr_next;
    end
  end

  // Outputs; the pin floats while deselected
  assign dout                   = dout_reg;
  assign dout_oe                = ~cs_s2;
  assign ready_n                = rdy_reg;
  assign crc_error              = crcerr_reg;
  assign continuous_read_enable = ifmode_reg[`IFM_CONTINUOUS_READ_ENABLE_BIT];
  assign chk_mode               = ifmode_reg[`IFM_CHK_MSB:`IFM_CHK_LSB];
  assign mode_word              = mode_reg;
  assign iface_reset            = rst_pulse_reg;

endmodule

/* dv/adc_serial_port_assertions.sv */
// Concurrent checks on the pins of the converter serial port
module adc_serial_port_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Serial pins
  input wire logic        cs_n,
  input wire logic        sclk,
  input wire logic        din,
  input wire logic        dout,
  input wire logic        dout_oe,
  // Converter result
  input wire logic        conv_valid,
  input wire logic [23:0] conv_data,
  // Status and configuration
  input wire logic        ready_n,
  input wire logic        crc_error,
  input wire logic        continuous_read_enable,
  input wire logic [1:0]  chk_mode,
  input wire logic [15:0] mode_word,
  input wire logic        iface_reset
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Ready rises first, then the fresh word pulls it low
  sequence s_update;
    ##1 ready_n ##1 !ready_n;
  endsequence
  // Four samples cover the select synchroniser
  sequence s_idle;
    cs_n [*4];
  endsequence

  a_oe_select: assert property ((!cs_n) [*4] |-> dout_oe)
    else $error("pin not driven while selected");
  a_oe_release: assert property (s_idle |-> !dout_oe)
    else $error("pin driven while deselected");
  a_update_order: assert property (conv_valid |-> s_update)
    else $error("ready order wrong on result update");
  a_flag_hold: assert property (s_idle ##0 crc_error |=> crc_error)
    else $error("fault flag lost without status read");
  a_config_hold: assert property (s_idle |=> $stable(mode_word) && $stable(chk_mode))
    else $error("configuration changed with no transfer");
  a_reset_clears: assert property (iface_reset |=> mode_word == 16'h0000 &&
    chk_mode == 2'h0 && !continuous_read_enable && !crc_error && ready_n)
    else $error("interface reset left a register set");
  a_reset_cause: assert property (iface_reset |-> din && !cs_n)
    else $error("interface reset without ones pattern");
  a_reset_pulse: assert property (iface_reset |=> !iface_reset)
    else $error("interface reset pulse too long");
endmodule

bind adc_serial_port adc_serial_port_assertions chk_i (
  .clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
  .conv_valid(conv_valid), .conv_data(conv_data), .ready_n(ready_n), .crc_error(crc_error),
  .continuous_read_enable(continuous_read_enable), .chk_mode(chk_mode),
  .mode_word(mode_word), .iface_reset(iface_reset)
);

/* dv/spi_host_model.sv */
// Host controller model driving the serial pins in clock mode 3
module spi_host_model (
  // System clock paces the link
  input wire logic clk,
  // Device side
  input wire logic dout,
  input wire logic dout_oe,
  // Host side
  output logic     cs_n,
  output logic     sclk,
  output logic     din
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle pins at time zero, link clock parked high
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Link clock of 8 system clocks; clock stands still outside frames
  task automatic xfer(input logic [63:0] tx, input int n, input bit keep,
                      output logic [63:0] rx);
    rx = '0;
    cs_n <= 1'b0;
    tick(4);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b0;
      din  <= tx[63 - i];
      tick(4);
      sclk <= 1'b1;
      // Sample mid-high, clear of the edge at which the device moves on
      tick(2);
      rx[63 - i] = dout_oe ? dout : ~dout;
      tick(2);
    end
    // Released data line shows a changed level, not the last bit
    if (!keep) begin
      cs_n <= 1'b1;
      din  <= ~din;
    end
    tick(8);
  endtask

  // Sixty-four clocks with the input held high
  task automatic ones64();
    cs_n <= 1'b0;
    tick(4);
    for (int i = 0; i < 64; i++) begin
      sclk <= 1'b0;
      din  <= 1'b1;
      tick(4);
      sclk <= 1'b1;
      tick(4);
    end
    tick(8);
    cs_n <= 1'b1;
    din  <= 1'b0;
    tick(8);
  endtask
endmodule

/* dv/adc_serial_port_bench.sv */
// Self-checking bench for the converter serial port
module adc_serial_port_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk;
  logic        rst;
  logic        cs_n;
  logic        sclk;
  logic        din;
  logic        dout;
  logic        dout_oe;
  logic        conv_valid;
  logic [23:0] conv_data;
  logic        ready_n;
  logic        crc_error;
  logic        continuous_read_enable;
  logic [1:0]  chk_mode;
  logic [15:0] mode_word;
  logic        iface_reset;
  logic [1:0]  cur_chk;
  logic        seen_rst;
  logic [31:0] q;
  logic [63:0] rx;
  logic [15:0] modes [3];
  int          fails;
  int          total_checks;

  adc_serial_port dut (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
                       .dout_oe(dout_oe), .conv_valid(conv_valid), .conv_data(conv_data),
                       .ready_n(ready_n), .crc_error(crc_error),
                       .continuous_read_enable(continuous_read_enable), .chk_mode(chk_mode),
                       .mode_word(mode_word), .iface_reset(iface_reset));
  spi_host_model host (.clk(clk), .dout(dout), .dout_oe(dout_oe), .cs_n(cs_n), .sclk(sclk),
                       .din(din));

  // System clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Latch the one-cycle reset pulse so a later look cannot miss it
  always @(posedge clk) begin
    if (rst) seen_rst <= 1'b0;
    else if (iface_reset) seen_rst <= 1'b1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Checksum worked bit by bit from the polynomial, or bytes folded
  function automatic logic [7:0] csum(input logic [39:0] m, input int nb, input bit x);
    logic [7:0] c;
    c = 8'h00;
    if (x) for (int i = 0; i < nb; i++) c ^= m[39 - 8 * i -: 8];
    else for (int i = 0; i < nb * 8; i++)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ m[39 - i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // One command frame; write checksum always polynomial, bad flips a bit
  task automatic xact(input logic [7:0] cmd, input logic [31:0] d, input int dn,
                      input bit bad, input bit keep, output logic [31:0] qo);
    logic [63:0] tx;
    logic [63:0] r;
    logic [7:0]  s;
    tx = {cmd, d << (32 - dn), 24'h0};
    s = csum({cmd, d << (32 - dn)}, 1 + dn / 8, 1'b0) ^ {7'h0, bad};
    if (cur_chk != 2'h0 && !cmd[6]) tx[55 - dn -: 8] = s;
    host.xfer(tx, 8 + dn + (cur_chk != 2'h0 ? 8 : 0), keep, r);
    qo = r[55 -: 32] >> (32 - dn);
    if (cur_chk != 2'h0 && cmd[6])
      chk("read_sum", csum({cmd, r[55 -: 32]}, 1 + dn / 8, cur_chk == 2'h1),
          r[55 - dn -: 8]);
  endtask

  // New conversion result, then a bounded wait for ready
  task automatic conv(input logic [23:0] v);
    int n;
    conv_valid <= 1'b1;
    conv_data  <= v;
    @(posedge clk);
    conv_valid <= 1'b0;
    n = 0;
    while (ready_n !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk("ready_low", 32'h0, ready_n);
    if (n == 50) final_report();
    repeat (3) @(posedge clk);
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    final_report();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    conv_valid = 1'b0;
    conv_data = 24'h0;
    cur_chk = 2'h0;
    modes = '{16'h000C, 16'h0004, 16'h0008};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    xact(8'h01, 32'h1234, 16, 0, 1, q);
    chk("mode_word", 32'h1234, mode_word);
    conv(24'hA5C30F);
    chk("pin_ready", 32'h2, {dout_oe, dout});
    xact(8'h44, 32'h0, 24, 0, 1, q);
    chk("data", 32'hA5C30F, q);
    chk("pin_after", 32'h3, {dout_oe, dout});
    xact(8'h44, 32'h0, 24, 0, 0, q);
    chk("data_again", 32'hA5C30F, q);
    for (int k = 0; k < 3; k++) begin
      xact(8'h02, {16'h0, modes[k]}, 16, 0, 0, q);
      cur_chk = modes[k][3:2];
      chk("chk_mode", cur_chk, chk_mode);
      xact(8'h41, 32'h0, 16, 0, 0, q);
      chk("mode_read", 32'h1234, q);
    end
    xact(8'h01, 32'h5555, 16, 1, 0, q);
    chk("bad_write", 32'h1234, mode_word);
    chk("crc_error", 32'h1, crc_error);
    xact(8'h40, 32'h0, 8, 0, 0, q);
    chk("status", 32'h3, q[7:6]);
    chk("crc_clear", 32'h0, crc_error);
    xact(8'h01, 32'hBEEF, 16, 0, 0, q);
    chk("good_write", 32'hBEEF, mode_word);
    xact(8'h02, 32'h0088, 16, 0, 0, q);
    chk("cont_on", 32'h1, continuous_read_enable);
    conv(24'h000000);
    host.xfer(64'h0, 32, 0, rx);
    chk("cont_data", 32'h0, rx[63:40]);
    chk("cont_sum", csum({8'h44, rx[63:32]}, 4, 1'b0), rx[39:32]);
    chk("read_once", 32'h1, ready_n);
    conv(24'h123456);
    host.xfer({8'h44, 56'h0}, 32, 0, rx);
    chk("cont_off", 32'h0, continuous_read_enable);
    host.ones64();
    chk("iface_reset", 32'h1, seen_rst);
    chk("regs_clear", 32'h0, {mode_word, chk_mode, crc_error});
    cur_chk = 2'h0;
    repeat (25000) @(posedge clk);
    xact(8'h01, 32'h00A5, 16, 0, 0, q);
    chk("after_reset", 32'h00A5, mode_word);
    final_report();
  end
endmodule
